/* module_sideband_control.sv */
// sideband control of a pluggable module: select, reset, low power,
// presence, open-drain interrupt and the lower 128-byte management page
// assumes host pull-ups on interrupt_n, sda and scl
`timescale 1ns/1ps
module module_sideband_control
    import sideband_pkg::*;
#(
    parameter int         INIT_CYC = INIT_CYC_DFLT,
    parameter logic [7:0] ID_VALUE = 8'h00  // arbitrary value
) (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic module_select_n_pin,
    input  wire logic module_reset_n,
    input  wire logic low_power_request,
    input  wire logic fault_event,
    input  wire logic scl,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    output logic      interrupt_n_o,
    output logic      interrupt_n_oe,
    output logic      module_present_n,
    output logic      low_power_mode
);
    logic       sel_m, sel_s, rst_m, rst_s, rst_d, lp_m, lp_s;
    logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic       scl_rise, scl_fall, start_ev, stop_ev, selected;
    logic [10:0] low_cnt_q;
    logic       long_low_q;
    logic [31:0] init_cnt_q;
    logic       init_pending_q, done_irq_q, fault_q;
    logic       soft_rst, init_done, rd_status, rd_flag;
    bus_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic [6:0] ptr_q;
    logic       is_read_q, ptr_loaded_q, nack_q;
    logic [7:0] ctrl_mem [CTRL_FIRST:7'h7F];
    logic       wr_en;
    logic       rd_load;
    logic [7:0] rd_byte;

    // pins pass two flops; pull-ups give inactive reset values
    always_ff @(posedge mclk) begin
        if (reset) begin
            sel_m <= 1'b1;
            sel_s <= 1'b1;
            rst_m <= 1'b1;
            rst_s <= 1'b1;
            rst_d <= 1'b1;
            lp_m  <= 1'b0;
            lp_s  <= 1'b0;
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sel_m <= module_select_n_pin;
            sel_s <= sel_m;
            rst_m <= module_reset_n;
            rst_s <= rst_m;
            rst_d <= rst_s;
            lp_m  <= low_power_request;
            lp_s  <= lp_m;
            scl_m <= scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    assign selected = ~sel_s;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

    // measure the reset-input low; short lows never qualify
    always_ff @(posedge mclk) begin
        if (reset) begin
            low_cnt_q  <= 11'h000;
            long_low_q <= 1'b0;
        end else if (rst_s) begin
            low_cnt_q  <= 11'h000;
            long_low_q <= 1'b0;
        end else begin
            if (low_cnt_q != 11'h7FF)
                low_cnt_q <= low_cnt_q + 11'h001;
            if (low_cnt_q >= 11'(RESET_MIN_CYC))
                long_low_q <= 1'b1;
        end
    end

    // qualified release starts the completion interval
    assign soft_rst  = rst_s & ~rst_d & long_low_q;
    assign init_done = init_pending_q && (init_cnt_q >= 32'(INIT_CYC - 1));

    always_ff @(posedge mclk) begin
        if (reset || soft_rst) begin
            init_pending_q <= 1'b1;
            init_cnt_q     <= 32'h0000_0000;
        end else if (init_done) begin
            init_pending_q <= 1'b0;
        end else if (init_pending_q) begin
            init_cnt_q <= init_cnt_q + 32'h0000_0001;
        end
    end

    // completion interrupt set on finish, cleared by a status read
    always_ff @(posedge mclk) begin
        if (reset || soft_rst)
            done_irq_q <= 1'b0;
        else if (init_done)
            done_irq_q <= 1'b1;
        else if (rd_status)
            done_irq_q <= 1'b0;
    end

    // sticky fault flag, clear on read, set wins
    always_ff @(posedge mclk) begin
        if (reset || soft_rst)
            fault_q <= 1'b0;
        else if (fault_event)
            fault_q <= 1'b1;
        else if (rd_flag)
            fault_q <= 1'b0;
    end

    // open drain: only pulls low, never drives high
    always_ff @(posedge mclk) begin
        if (reset)
            interrupt_n_oe <= 1'b0;
        else
            interrupt_n_oe <= done_irq_q |
                (fault_q & ~ctrl_mem[MASK_BYTE][MASK_BIT]);
    end
    assign interrupt_n_o = 1'b0;

    always_ff @(posedge mclk) begin
        if (reset)
            low_power_mode <= 1'b0;
        else
            low_power_mode <= lp_s;
    end
    assign module_present_n = 1'b0;

    // one fixed lower page; pointer wraps inside 128 bytes
    function automatic logic [7:0] page_byte(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == ID_BYTE)
            v = ID_VALUE;
        else if (a == STATUS_BYTE)
            v[NOT_READY_BIT] = init_pending_q;
        else if (a == FLAG_BYTE)
            v[FAULT_BIT] = fault_q;
        else if (a >= CTRL_FIRST)
            v = ctrl_mem[a];
        return v;
    endfunction

    // byte at the pointer, ready for the shifter on a read load
    always_comb begin
        rd_byte = page_byte(ptr_q);
    end

    assign rd_load   = scl_fall && ((state_q == S_ACK_A && is_read_q) ||
                       (state_q == S_ACK_R && !nack_q));
    assign rd_status = rd_load && ptr_q == STATUS_BYTE;
    assign rd_flag   = rd_load && ptr_q == FLAG_BYTE;
    assign wr_en     = scl_fall && state_q == S_WR && cnt_q == BITS_PER_BYTE &&
                       ptr_loaded_q && ptr_q >= CTRL_FIRST;

    // writable settings return to default on any full reset
    always_ff @(posedge mclk) begin
        if (reset || soft_rst) begin
            for (int i = CTRL_FIRST; i < 128; i++)
                ctrl_mem[i] <= CTRL_DEFAULT;
        end else if (wr_en) begin
            ctrl_mem[ptr_q] <= shift_q;
        end
    end

    // 2-wire slave; deselect forces idle and releases sda
    always_ff @(posedge mclk) begin
        if (reset || !selected || stop_ev) begin
            state_q      <= S_IDLE;
            sda_oe       <= 1'b0;
            cnt_q        <= 4'h0;
            shift_q      <= 8'h00;
            is_read_q    <= 1'b0;
            ptr_loaded_q <= 1'b0;
            nack_q       <= 1'b0;
        end else if (start_ev) begin
            state_q      <= S_ADDR;
            sda_oe       <= 1'b0;
            cnt_q        <= 4'h0;
            ptr_loaded_q <= 1'b0;
        end else begin
            case (state_q)
                S_ADDR, S_WR: begin
                    if (scl_rise && cnt_q != BITS_PER_BYTE) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        if (state_q == S_WR) begin
                            state_q      <= S_ACK_W;
                            sda_oe       <= 1'b1;
                            ptr_loaded_q <= 1'b1;
                        end else if (shift_q[7:1] == DEV_ADDR) begin
                            state_q   <= S_ACK_A;
                            sda_oe    <= 1'b1;
                            is_read_q <= shift_q[0];
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_ACK_A, S_ACK_W: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (rd_load) begin
                            state_q <= S_RD;
                            sda_oe  <= ~rd_byte[7];
                            shift_q <= {rd_byte[6:0], 1'b0};
                        end else begin
                            state_q <= S_WR;
                            sda_oe  <= 1'b0;
                        end
                    end
                end
                S_RD: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        state_q <= S_ACK_R;
                        sda_oe  <= 1'b0;
                    end else if (scl_fall) begin
                        sda_oe  <= ~shift_q[7];
                        shift_q <= {shift_q[6:0], 1'b0};
                    end
                end
                S_ACK_R: begin
                    if (scl_rise) begin
                        nack_q <= sda_s;
                    end else if (scl_fall && nack_q) begin
                        state_q <= S_IDLE;
                    end else if (scl_fall) begin
                        state_q <= S_RD;
                        cnt_q   <= 4'h0;
                        sda_oe  <= ~rd_byte[7];
                        shift_q <= {rd_byte[6:0], 1'b0};
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    sda_oe  <= 1'b0;
                end
            endcase
        end
    end
    assign sda_o = 1'b0;

    // byte pointer: first written byte sets it, each byte advances it
    always_ff @(posedge mclk) begin
        if (reset)
            ptr_q <= 7'h00;
        else if (selected && state_q == S_WR && scl_fall &&
                 cnt_q == BITS_PER_BYTE)
            ptr_q <= ptr_loaded_q ? ptr_q + 7'h01 : shift_q[6:0];
        else if (rd_load)
            ptr_q <= ptr_q + 7'h01;
    end

    a_desel_quiet: assert property (@(posedge mclk) disable iff (reset)
        !selected |=> !sda_oe) else $error("sda driven while deselected");
    a_addr_ack: assert property (@(posedge mclk) disable iff (reset)
        state_q == S_ACK_A |-> sda_oe) else $error("address not acked");
    a_short_low_ignored: assert property (@(posedge mclk) disable iff (reset)
        rst_s && !rst_d && !long_low_q && !init_pending_q |=> !init_pending_q)
        else $error("short reset low started init");
    a_long_low_reset: assert property (@(posedge mclk) disable iff (reset)
        soft_rst |=> init_pending_q && init_cnt_q == 32'h0
        && ctrl_mem[MASK_BYTE] == CTRL_DEFAULT)
        else $error("qualified reset not applied");
    a_done_irq: assert property (@(posedge mclk) disable iff (reset)
        $fell(init_pending_q) |-> done_irq_q ##1 interrupt_n_oe)
        else $error("completion interrupt missing");
    a_powerup_init: assert property (@(posedge mclk)
        reset |=> init_pending_q && !done_irq_q)
        else $error("power-up did not start init");
    a_lowpower_follow: assert property (@(posedge mclk) disable iff (reset)
        lp_s |=> low_power_mode) else $error("low power not entered");
    a_present_low: assert property (@(posedge mclk)
        module_present_n == 1'b0) else $error("presence not low");
    a_fault_irq: assert property (@(posedge mclk) disable iff (reset)
        fault_q && !ctrl_mem[MASK_BYTE][MASK_BIT] |=> interrupt_n_oe)
        else $error("fault not reported");
    a_int_open_drain: assert property (@(posedge mclk)
        interrupt_n_o == 1'b0) else $error("interrupt driven high");
endmodule

/* sideband_pkg.sv */
// constants for the module sideband control block
// assumes a 100 MHz mclk and 2-wire pins that the host pulls up
// Functional notes
// - answer management bus while select is low
// - ignore all bus traffic while select high
// - undriven select reads as not selected
// - undriven reset input reads as inactive
// - long reset low gives full module reset
// - full reset restores writable settings to default
// - completion interval starts at reset release
// - completion interrupt with not-ready bit cleared
// - power-up raises completion interrupt unprompted
// - low-power request enters reduced-power state
// - presence output low while inserted
// - interrupt low reports fault or critical status
// - interrupt output sinks or floats only
// - lower space is one fixed 128-byte page
package sideband_pkg;
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         T_RESET_MIN_NS  = 10000;
    localparam int         RESET_MIN_CYC   =
        (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         T_INIT_US       = 2000;
    localparam int         INIT_CYC_DFLT   = T_INIT_US * 1000 / CLK_PERIOD_NS;
    localparam logic [6:0] DEV_ADDR        = 7'h50;
    localparam logic [6:0] ID_BYTE         = 7'h00;
    localparam logic [6:0] STATUS_BYTE     = 7'h02;
    localparam int         NOT_READY_BIT   = 0;
    localparam logic [6:0] FLAG_BYTE       = 7'h03;
    localparam int         FAULT_BIT       = 0;
    localparam logic [6:0] CTRL_FIRST      = 7'h56;
    localparam logic [6:0] MASK_BYTE       = 7'h64;
    localparam int         MASK_BIT        = 0;
    localparam logic [7:0] CTRL_DEFAULT    = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

    typedef enum logic [6:0] {
        S_IDLE  = 7'b0000001,
        S_ADDR  = 7'b0000010,
        S_ACK_A = 7'b0000100,
        S_WR    = 7'b0001000,
        S_ACK_W = 7'b0010000,
        S_RD    = 7'b0100000,
        S_ACK_R = 7'b1000000
    } bus_state_t;
endpackage

/* host_model.sv */
// host board model: drives scl and pulls sda low for 2-wire transfers
// assumes the bench resolves sda with a pull-up and calls wr and rd
`timescale 1ns/1ps
module host_model
    import sideband_pkg::*;
(
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic half();
        repeat (6) @(posedge mclk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        repeat (2) @(posedge mclk);
        sda_low <= !b;
        half();
        scl <= 1'b1;
        half();
        r = sda;
        scl <= 1'b0;
    endtask
    task automatic start(input logic rep);
        if (rep) begin
            half();
            sda_low <= 1'b0;
            half();
            scl <= 1'b1;
        end
        half();
        sda_low <= 1'b1;
        half();
        scl <= 1'b0;
    endtask
    task automatic stop();
        half();
        sda_low <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_low <= 1'b0;
        half();
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(1'b1, r);
    endtask
    task automatic wr(input logic [6:0] p, input logic [7:0] d,
                      output logic ok);
        logic a0, a1, a2;
        start(1'b0);
        put({DEV_ADDR, 1'b0}, a0);
        put({1'b0, p}, a1);
        put(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [6:0] p, output logic [7:0] d,
                      output logic ok);
        logic a0, a1, a2;
        start(1'b0);
        put({DEV_ADDR, 1'b0}, a0);
        put({1'b0, p}, a1);
        start(1'b1);
        put({DEV_ADDR, 1'b1}, a2);
        get(d);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

/* test_module_sideband_control.sv */
// self-checking bench for module_sideband_control
// assumes host_model as the 2-wire host and pull-ups on shared lines
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_module_sideband_control
    import sideband_pkg::*;
    ;
    localparam int INIT_SIM = 1500;
    localparam logic [7:0] ID_SIM = 8'h3C;  // arbitrary value
    logic       mclk, reset, sel_on, rst_on, lp_req, fault, scl, host_low;
    logic       sda_o, sda_oe, irq_o, irq_oe, present_n, lp_mode, ok;
    logic [7:0] rdat;
    int         fails;
    int         n_tests;
    tri1        sel_n, rst_n, sda, irq_n;
    assign sel_n = sel_on ? 1'b0 : 1'bz;
    assign rst_n = rst_on ? 1'b0 : 1'bz;
    assign sda = sda_oe ? sda_o : 1'bz;
    assign sda = host_low ? 1'b0 : 1'bz;
    assign irq_n = irq_oe ? irq_o : 1'bz;
    module_sideband_control #(.INIT_CYC(INIT_SIM), .ID_VALUE(ID_SIM)) dut_u (
        .mclk(mclk), .reset(reset), .module_select_n_pin(sel_n),
        .module_reset_n(rst_n), .low_power_request(lp_req),
        .fault_event(fault), .scl(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .interrupt_n_o(irq_o), .interrupt_n_oe(irq_oe),
        .module_present_n(present_n), .low_power_mode(lp_mode));
    host_model host_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(host_low));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic irq_after(output int n);
        n = 0;
        while (irq_n !== 1'b0 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic pulse_fault();
        fault <= 1'b1;
        @(posedge mclk);
        fault <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic t_power();
        int n;
        host_u.rd(STATUS_BYTE, rdat, ok);
        `CHK(rdat[NOT_READY_BIT], 1'b1)
        irq_after(n);
        `CHK(n > 0, 1'b1)
        `CHK(irq_n, 1'b0)
        `CHK(irq_o, 1'b0)
        `CHK(present_n, 1'b0)
        host_u.rd(STATUS_BYTE, rdat, ok);
        `CHK(rdat[NOT_READY_BIT], 1'b0)
        repeat (4) @(posedge mclk);
        `CHK(irq_n, 1'b1)
        host_u.rd(ID_BYTE, rdat, ok);
        `CHK(rdat, ID_SIM)
        $display("power-up test done");
    endtask
    task automatic t_rw();
        host_u.wr(CTRL_FIRST, 8'h12, ok);
        `CHK(ok, 1'b1)
        host_u.rd(CTRL_FIRST, rdat, ok);
        `CHK(rdat, 8'h12)
        sel_on <= 1'b0;
        host_u.wr(CTRL_FIRST + 7'h01, 8'h34, ok);
        `CHK(ok, 1'b0)
        host_u.rd(CTRL_FIRST, rdat, ok);
        `CHK(ok, 1'b0)
        `CHK(rdat, 8'hFF)
        sel_on <= 1'b1;
        host_u.rd(CTRL_FIRST + 7'h01, rdat, ok);
        `CHK(rdat, CTRL_DEFAULT)
        $display("select test done");
    endtask
    task automatic t_lowpower();
        lp_req <= 1'b1;
        repeat (5) @(posedge mclk);
        `CHK(lp_mode, 1'b1)
        lp_req <= 1'b0;
        repeat (5) @(posedge mclk);
        `CHK(lp_mode, 1'b0)
        $display("low-power test done");
    endtask
    task automatic t_fault();
        pulse_fault();
        `CHK(irq_n, 1'b0)
        host_u.rd(FLAG_BYTE, rdat, ok);
        `CHK(rdat[FAULT_BIT], 1'b1)
        repeat (4) @(posedge mclk);
        `CHK(irq_n, 1'b1)
        host_u.rd(FLAG_BYTE, rdat, ok);
        `CHK(rdat[FAULT_BIT], 1'b0)
        host_u.wr(MASK_BYTE, 8'h01, ok);
        `CHK(ok, 1'b1)
        pulse_fault();
        `CHK(irq_n, 1'b1)
        host_u.rd(FLAG_BYTE, rdat, ok);
        `CHK(rdat[FAULT_BIT], 1'b1)
        host_u.wr(MASK_BYTE, 8'h00, ok);
        $display("fault test done");
    endtask
    task automatic t_short();
        host_u.wr(CTRL_FIRST, 8'h5A, ok);
        rst_on <= 1'b1;
        repeat (RESET_MIN_CYC - 10) @(posedge mclk);
        rst_on <= 1'b0;
        repeat (INIT_SIM + 10) @(posedge mclk);
        `CHK(irq_n, 1'b1)
        host_u.rd(CTRL_FIRST, rdat, ok);
        `CHK(rdat, 8'h5A)
        $display("short reset test done");
    endtask
    task automatic t_long();
        int n;
        rst_on <= 1'b1;
        repeat (RESET_MIN_CYC + 10) @(posedge mclk);
        rst_on <= 1'b0;
        irq_after(n);
        `CHK(n >= INIT_SIM && n <= INIT_SIM + 6, 1'b1)
        host_u.rd(CTRL_FIRST, rdat, ok);
        `CHK(rdat, CTRL_DEFAULT)
        host_u.rd(STATUS_BYTE, rdat, ok);
        `CHK(rdat[NOT_READY_BIT], 1'b0)
        $display("long reset test done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        fails++;
        test_done();
    end
    initial begin
        fails = 0;
        n_tests = 0;
        reset = 1'b1;
        sel_on = 1'b1;
        rst_on = 1'b0;
        lp_req = 1'b0;
        fault = 1'b0;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        t_power();
        t_rw();
        t_lowpower();
        t_fault();
        t_short();
        t_long();
        test_done();
    end
endmodule
